// *** bench/qmc_encoder_model.sv ***
module qmc_encoder_model (
	input  wire logic aclk,
	output logic      count_pulse,
	output logic      count_up
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		count_pulse = 1'b0;
		count_up    = 1'b0;
	end

	// One decoded step per call; idle direction toggles so it is never trusted
	task automatic drive(input logic p, input logic up);
		count_pulse <= p;
		count_up    <= p ? up : ~count_up;
		@(posedge aclk);
	endtask
endmodule

// *** bench/tb_qmc_counter.sv ***
module tb_qmc_counter
	import qmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [5:0] MODES [6] = '{FCT_ONCE_FWD, FCT_ONCE_BWD, FCT_ONCE_NON,
		FCT_PER_FWD, FCT_PER_BWD, FCT_PER_NON};

	logic               aclk, aresetn, ce, count_pulse, count_up, irq, gate_open;
	logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic               s_axi_rvalid, s_axi_rready;
	logic [7:0]         s_axi_awaddr, s_axi_araddr;
	logic [31:0]        s_axi_wdata, s_axi_rdata, count_value, seed, rd;
	logic [3:0]         s_axi_wstrb;
	logic [1:0]         s_axi_bresp, s_axi_rresp, rsp, msk;
	logic signed [31:0] ld, ev, exp_v;
	logic               exp_gate, ofl, ufl, sw, gopt, reload_nx;
	logic [5:0]         fct;
	int                 n_mismatch, tests_run;
	int                 cyc = 0;

	qmc_counter qmc_counter_i (.aclk, .aresetn, .ce, .count_pulse, .count_up,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq, .gate_open, .count_value);

	qmc_encoder_model qmc_encoder_model_i (.aclk, .count_pulse, .count_up);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch = n_mismatch + 1;
			complete_run();
		end
	end

	// ==========================================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Returns {overflow, underflow, auto stop, next value}
	function automatic logic [34:0] ref_step(input logic signed [31:0] v, input logic up);
		logic fwd, bwd, once;
		fwd  = fct inside {FCT_ONCE_FWD, FCT_PER_FWD};
		bwd  = fct inside {FCT_ONCE_BWD, FCT_PER_BWD};
		once = |fct[2:0];
		if (fwd && up && v == ev - CNT_ONE) return {2'b00, once, ld};
		if (bwd && !up && v == ev + CNT_ONE) return {2'b00, once, ld};
		if (up && v == CNT_MAX) return {2'b10, fct == FCT_ONCE_NON, CNT_MIN};
		if (!up && v == CNT_MIN) return {2'b01, fct == FCT_ONCE_NON, CNT_MAX};
		return {3'b000, up ? v + CNT_ONE : v - CNT_ONE};
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================
	// Register bus master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge aclk);
			ah  = s_axi_awvalid & s_axi_awready;
			wh  = s_axi_wvalid & s_axi_wready;
			bh  = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic arh, rh;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		rh = 1'b0;
		while (!rh) begin
			@(negedge aclk);
			arh = s_axi_arvalid & s_axi_arready;
			rh  = s_axi_rvalid;
			rd  = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (arh) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// ==========================================
	// Counter stimulus and expectation
	task automatic set_gate(input logic g);
		axi_wr(ADDR_CTRL, {31'h0, g});
		repeat (2) @(posedge aclk);
		if (g && !sw) begin
			if (!gopt || reload_nx) exp_v = ld;
			exp_gate  = 1'b1;
			reload_nx = 1'b0;
		end
		if (!g) exp_gate = 1'b0;
		sw = g;
	endtask

	task automatic pulses(input int n, input logic dir, input logic rnd);
		logic        up;
		logic [34:0] r;
		for (int i = 0; i < n; i++) begin
			up = (rnd && xs() % 4 == 0) ? !dir : dir;
			qmc_encoder_model_i.drive(1'b1, up);
			if (exp_gate) begin
				r     = ref_step(exp_v, up);
				exp_v = r[31:0];
				ofl   = ofl | r[34];
				ufl   = ufl | r[33];
				if (r[32]) begin
					exp_gate  = 1'b0;
					reload_nx = fct[1:0] != 2'b00;
				end
			end
		end
		qmc_encoder_model_i.drive(1'b0, 1'b0);
	endtask

	task automatic chk_state();
		axi_rd(ADDR_STATUS);
		check("status", rd, {29'h0, exp_gate, ufl, ofl});
		check("count", count_value, exp_v);
		check("gate", {31'h0, gate_open}, {31'h0, exp_gate});
		check("irq", {31'h0, irq}, {31'h0, |({ufl, ofl} & msk)});
	endtask

	// ==========================================
	// Main sequence
	initial begin
		logic dir;
		seed = 32'h06FF40A4;
		n_mismatch = 0;
		tests_run = 0;
		aresetn = 1'b0;
		ce = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{ld, ev, exp_v} = {3{32'h0}};
		{exp_gate, ofl, ufl, sw, gopt, msk} = 7'h00;
		reload_nx = 1'b1;
		fct = FCT_ENDLESS;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_state();
		axi_rd(8'h1C);
		check("unmapped resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		check("unmapped data", rd, 32'h0);
		axi_wr(ADDR_COUNT, 32'h12345678);
		// Endless wrap in both directions
		ld = CNT_MAX - CNT_ONE;
		msk = 2'b11;
		axi_wr(ADDR_LOAD, ld);
		check("write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
		axi_rd(ADDR_LOAD);
		check("load readback", rd, ld);
		axi_wr(ADDR_MASK, {30'h0, msk});
		set_gate(1'b1);
		chk_state();
		pulses(2, 1'b1, 1'b0);
		chk_state();
		pulses(1, 1'b0, 1'b0);
		chk_state();
		axi_wr(ADDR_CTRL, 32'h3);
		{ofl, ufl} = 2'b00;
		chk_state();
		// Frozen while the clock enable is low
		ce <= 1'b0;
		qmc_encoder_model_i.drive(1'b1, 1'b1);
		ce <= 1'b1;
		qmc_encoder_model_i.drive(1'b0, 1'b0);
		chk_state();
		// Abort then interrupt gate options
		pulses(5, 1'b1, 1'b1);
		set_gate(1'b0);
		pulses(3, 1'b1, 1'b1);
		chk_state();
		set_gate(1'b1);
		chk_state();
		gopt = 1'b1;
		axi_wr(ADDR_CONFIG, 32'h8000);
		pulses(5, 1'b0, 1'b1);
		set_gate(1'b0);
		set_gate(1'b1);
		chk_state();
		// Every once and periodic variant, bounds near both limits
		for (int k = 0; k < 6; k++) begin
			fct = MODES[k];
			gopt = 1'b0;
			msk = 2'(xs() % 4);
			axi_wr(ADDR_CONFIG, {16'h0, gopt, 9'h0, fct});
			axi_wr(ADDR_MASK, {30'h0, msk});
			dir = (fct inside {FCT_ONCE_BWD, FCT_PER_BWD}) ? 1'b0 : xs() % 2 == 0;
			ld = (fct inside {FCT_ONCE_FWD, FCT_PER_FWD}) ? CNT_MIN + 32'sh2 :
				dir ? CNT_MAX - 32'sh3 : CNT_MIN + 32'sh3;
			ev = dir ? ld + 32'sh5 : ld - 32'sh5;
			axi_wr(ADDR_LOAD, ld);
			axi_wr(ADDR_END, ev);
			set_gate(1'b0);
			set_gate(1'b1);
			pulses(16, dir, 1'b1);
			chk_state();
			gopt = 1'b1;
			axi_wr(ADDR_CONFIG, {16'h0, gopt, 9'h0, fct});
			set_gate(1'b0);
			set_gate(1'b1);
			chk_state();
			pulses(2, dir, 1'b0);
			chk_state();
			axi_wr(ADDR_STATUS, 32'h3);
			{ofl, ufl} = 2'b00;
			chk_state();
		end
		complete_run();
	end
endmodule

// *** hdl/qmc_counter.sv ***
// What this block does
// - No main direction uses the full signed 32-bit range down to minus two^31.
// - Endless mode starts at load value; up pulse at top wraps to bottom.
// - Endless mode: down pulse at bottom wraps to top and continues.
// - Wraps set sticky overflow or underflow flags; enabled flags raise interrupt.
// - Abort option: gate close then reopen reloads the load value.
// - Interrupt option: gate close then reopen resumes from the held value.
// - Once, no direction: wrap to opposite bound, close gate, set flag.
// - Once forward: up pulse at end minus one loads load value, closes gate.
// - Once backward: down pulse at end plus one loads load value, closes gate.
// - After directional once stop, gate rising edge restarts from load value.
// - Forward direction may count down past the lower bound.
// - Backward direction may count up past the upper bound.
// - Periodic, no direction: wrap at bounds and keep the gate open.
// - Periodic forward: up pulse at end minus one reloads, gate stays open.
// - Periodic backward: down pulse at end plus one reloads, gate stays open.
// - Six-bit function field, zero endless, one-hot once and periodic variants.
// - Gate option bit: zero aborts, one interrupts.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
module qmc_counter
	import qmc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        count_pulse,
	input  wire logic        count_up,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq,
	output logic             gate_open,
	output logic [31:0]      count_value
);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic qmc_mode_e decode_mode(input logic [5:0] f);
		case (f)
			FCT_ONCE_FWD: return QMC_ONCE_FWD;
			FCT_ONCE_BWD: return QMC_ONCE_BWD;
			FCT_ONCE_NON: return QMC_ONCE_NON;
			FCT_PER_FWD:  return QMC_PER_FWD;
			FCT_PER_BWD:  return QMC_PER_BWD;
			FCT_PER_NON:  return QMC_PER_NON;
			// Unknown codes fall back to endless counting
			default:      return QMC_ENDLESS;
		endcase
	endfunction

	// ==========================================================
	// State
	logic               aw_held;
	logic               w_held;
	logic [7:0]         aw_addr;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               wr_fire;
	logic               software_gate;
	logic               software_gate_d;
	logic               clear_status_request;
	qmc_cfg_s           cfg;
	logic signed [31:0] load_value;
	logic signed [31:0] end_value;
	logic signed [31:0] count;
	logic               gate;
	logic               started;
	logic               reload_pending;
	qmc_flags_s         flags;
	qmc_flags_s         mask;
	qmc_mode_e          mode;
	logic               dir_fwd;
	logic               dir_bwd;
	logic               is_once;
	logic               gate_rise;
	logic               gate_fall;
	logic signed [31:0] next_count;
	logic               next_gate;
	logic               next_reload;
	logic               set_ovf;
	logic               set_unf;

	assign mode      = decode_mode(cfg.count_function_select);
	assign dir_fwd   = (mode == QMC_ONCE_FWD) || (mode == QMC_PER_FWD);
	assign dir_bwd   = (mode == QMC_ONCE_BWD) || (mode == QMC_PER_BWD);
	assign is_once   = (mode == QMC_ONCE_FWD) || (mode == QMC_ONCE_BWD) ||
		(mode == QMC_ONCE_NON);
	assign gate_rise = software_gate && !software_gate_d;
	assign gate_fall = !software_gate && software_gate_d;

	// ==========================================================
	// AXI4-Lite write channel
	// Ready held low while frozen so no beat is lost with ce low
	assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr)
					ADDR_CTRL, ADDR_CONFIG, ADDR_LOAD, ADDR_END,
					ADDR_STATUS, ADDR_MASK: s_axi_bresp <= RESP_OKAY;
					default:                s_axi_bresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	assign s_axi_arready = ce && !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				case (s_axi_araddr)
					ADDR_CTRL:   s_axi_rdata <= 32'(software_gate);
					ADDR_CONFIG: s_axi_rdata <= {16'h0000, cfg.gate_interrupt, 9'h000,
						cfg.count_function_select};
					ADDR_LOAD:   s_axi_rdata <= load_value;
					ADDR_END:    s_axi_rdata <= end_value;
					ADDR_COUNT:  s_axi_rdata <= count;
					ADDR_STATUS: s_axi_rdata <= {29'h00000000, gate, flags};
					ADDR_MASK:   s_axi_rdata <= {30'h00000000, mask};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			software_gate        <= 1'b0;
			software_gate_d            <= 1'b0;
			clear_status_request <= 1'b0;
			cfg                  <= '0;
			load_value           <= LOAD_RST;
			end_value            <= END_RST;
			mask                 <= '0;
		end else if (ce) begin
			software_gate_d            <= software_gate;
			clear_status_request <= 1'b0;
			if (wr_fire && w_strb[0] && aw_addr == ADDR_CTRL) begin
				software_gate        <= w_data[CTRL_GATE_BIT];
				clear_status_request <= w_data[CTRL_CLR_BIT];
			end
			if (wr_fire && aw_addr == ADDR_CONFIG) begin
				if (w_strb[0]) begin
					cfg.count_function_select <= w_data[CFG_FUNC_MSB:CFG_FUNC_LSB];
				end
				if (w_strb[1]) begin
					cfg.gate_interrupt <= w_data[CFG_GATE_BIT];
				end
			end
			if (wr_fire && aw_addr == ADDR_LOAD) begin
				load_value <= apply_strb(load_value, w_data, w_strb);
			end
			if (wr_fire && aw_addr == ADDR_END) begin
				end_value <= apply_strb(end_value, w_data, w_strb);
			end
			if (wr_fire && w_strb[0] && aw_addr == ADDR_MASK) begin
				mask <= w_data[STS_UNF_BIT:STS_OVF_BIT];
			end
		end
	end

	// ==========================================================
	// Counting core
	always_comb begin
		next_count  = count;
		next_gate   = gate;
		next_reload = reload_pending;
		set_ovf     = 1'b0;
		set_unf     = 1'b0;
		if (gate_rise) begin
			// Gate edge wins over a pulse in the same cycle
			next_gate   = 1'b1;
			next_reload = 1'b0;
			if (!cfg.gate_interrupt || !started || reload_pending) begin
				next_count = load_value;
			end
		end else if (gate_fall) begin
			next_gate = 1'b0;
		end else if (gate && count_pulse) begin
			if (count_up) begin
				if (dir_fwd && count == end_value - CNT_ONE) begin
					next_count = load_value;
					if (is_once) begin
						next_gate   = 1'b0;
						next_reload = 1'b1;
					end
				end else if (count == CNT_MAX) begin
					// Backward direction also wraps here
					next_count = CNT_MIN;
					set_ovf    = 1'b1;
					if (mode == QMC_ONCE_NON) begin
						next_gate = 1'b0;
					end
				end else begin
					next_count = count + CNT_ONE;
				end
			end else begin
				if (dir_bwd && count == end_value + CNT_ONE) begin
					next_count = load_value;
					if (is_once) begin
						next_gate   = 1'b0;
						next_reload = 1'b1;
					end
				end else if (count == CNT_MIN) begin
					next_count = CNT_MAX;
					set_unf    = 1'b1;
					if (mode == QMC_ONCE_NON) begin
						next_gate = 1'b0;
					end
				end else begin
					next_count = count - CNT_ONE;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count          <= LOAD_RST;
			gate           <= 1'b0;
			started        <= 1'b0;
			reload_pending <= 1'b0;
		end else if (ce) begin
			count          <= next_count;
			gate           <= next_gate;
			reload_pending <= next_reload;
			if (gate_rise) begin
				started <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Status flags and interrupt; a new event beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= '0;
		end else if (ce) begin
			if (set_ovf) begin
				flags.overflow_flag <= 1'b1;
			end else if (clear_status_request ||
				(wr_fire && w_strb[0] && aw_addr == ADDR_STATUS &&
				w_data[STS_OVF_BIT])) begin
				flags.overflow_flag <= 1'b0;
			end
			if (set_unf) begin
				flags.underflow_flag <= 1'b1;
			end else if (clear_status_request ||
				(wr_fire && w_strb[0] && aw_addr == ADDR_STATUS &&
				w_data[STS_UNF_BIT])) begin
				flags.underflow_flag <= 1'b0;
			end
		end
	end

	assign irq         = |(flags & mask);
	assign gate_open   = gate;
	assign count_value = count;

	// ==========================================================
	// Checks
	chk_wrap_up_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate && !gate_rise && !gate_fall && count_pulse && count_up &&
		mode == QMC_ENDLESS && count == CNT_MAX |=> count == CNT_MIN && flags.overflow_flag)
		else $error("upward wrap failed");
	chk_wrap_down_unf: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate && !gate_rise && !gate_fall && count_pulse && !count_up &&
		(mode == QMC_ENDLESS || mode == QMC_PER_NON) && count == CNT_MIN
		|=> count == CNT_MAX && gate &&
		flags.underflow_flag)
		else $error("downward wrap failed");
	chk_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == ((flags.overflow_flag && mask.overflow_flag) ||
		(flags.underflow_flag && mask.underflow_flag)))
		else $error("interrupt does not follow flags");
	chk_irq_event: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && set_ovf |=> flags.overflow_flag && (irq || !mask.overflow_flag))
		else $error("overflow event did not raise flag or interrupt");
	chk_abort_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate_rise && !cfg.gate_interrupt |=> count == $past(load_value) && gate)
		else $error("abort reopen did not reload");
	chk_interrupt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate_rise && cfg.gate_interrupt && started && !reload_pending
		|=> $stable(count) && gate)
		else $error("interrupt reopen lost value");
	chk_once_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate && !gate_rise && !gate_fall && count_pulse && count_up &&
		mode == QMC_ONCE_NON && count == CNT_MAX |=> !gate ##1 (!ce || $stable(count)))
		else $error("once mode did not stop");
	chk_fwd_end: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate && !gate_rise && !gate_fall && count_pulse && count_up &&
		mode == QMC_ONCE_FWD && count == end_value - CNT_ONE
		|=> count == $past(load_value) && !gate && reload_pending)
		else $error("forward end not handled");
	chk_bwd_end: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate && !gate_rise && !gate_fall && count_pulse && !count_up &&
		mode == QMC_ONCE_BWD && count == end_value + CNT_ONE
		|=> count == $past(load_value) && !gate)
		else $error("backward end not handled");
	chk_per_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate && !gate_rise && !gate_fall && count_pulse && count_up &&
		mode == QMC_PER_FWD && count == end_value - CNT_ONE
		|=> count == $past(load_value) && gate)
		else $error("periodic forward reload failed");
	chk_gate_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !gate && !gate_rise |=> $stable(count))
		else $error("count moved with gate closed");
	chk_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && gate && !gate_rise && !gate_fall && count_pulse && count_up &&
		mode == QMC_ENDLESS && count != CNT_MAX |=> count == $past(count) + CNT_ONE)
		else $error("count step wrong");

endmodule

// *** hdl/qmc_pkg.sv ***
package qmc_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_CONFIG = 8'h04;
	localparam logic [7:0]  ADDR_LOAD   = 8'h08;
	localparam logic [7:0]  ADDR_END    = 8'h0C;
	localparam logic [7:0]  ADDR_COUNT  = 8'h10;
	localparam logic [7:0]  ADDR_STATUS = 8'h14;
	localparam logic [7:0]  ADDR_MASK   = 8'h18;

	// ==========================================================
	// Field positions
	localparam int CTRL_GATE_BIT  = 0;
	localparam int CTRL_CLR_BIT   = 1;
	localparam int CFG_FUNC_LSB   = 0;
	localparam int CFG_FUNC_MSB   = 5;
	localparam int CFG_GATE_BIT   = 15;
	localparam int STS_OVF_BIT    = 0;
	localparam int STS_UNF_BIT    = 1;
	localparam int STS_GATE_BIT   = 2;

	// ==========================================================
	// Counter function codes
	localparam logic [5:0]  FCT_ENDLESS  = 6'h00;
	localparam logic [5:0]  FCT_ONCE_FWD = 6'h01;
	localparam logic [5:0]  FCT_ONCE_BWD = 6'h02;
	localparam logic [5:0]  FCT_ONCE_NON = 6'h04;
	localparam logic [5:0]  FCT_PER_FWD  = 6'h08;
	localparam logic [5:0]  FCT_PER_BWD  = 6'h10;
	localparam logic [5:0]  FCT_PER_NON  = 6'h20;

	// ==========================================================
	// Count range and reset values
	localparam logic signed [31:0] CNT_MIN   = 32'sh80000000;
	localparam logic signed [31:0] CNT_MAX   = 32'sh7FFFFFFF;
	localparam logic signed [31:0] CNT_ONE   = 32'sh00000001;
	localparam logic signed [31:0] LOAD_RST  = 32'sh00000000;
	localparam logic signed [31:0] END_RST   = 32'sh00000000;
	localparam logic [1:0]         RESP_OKAY = 2'h0;
	localparam logic [1:0]         RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		QMC_ENDLESS, QMC_ONCE_FWD, QMC_ONCE_BWD, QMC_ONCE_NON,
		QMC_PER_FWD, QMC_PER_BWD, QMC_PER_NON
	} qmc_mode_e;

	typedef struct packed {
		logic       gate_interrupt;
		logic [5:0] count_function_select;
	} qmc_cfg_s;

	typedef struct packed {
		logic underflow_flag;
		logic overflow_flag;
	} qmc_flags_s;

endpackage
